// ===== src/fruos_pkg.sv
// Purpose: Shared constants, types and helpers for the file-register unary datapath
// Assumes: 8-bit data, 7-bit file addresses, one clock
// Notes:   Opcode values are local encodings of this datapath
`default_nettype none
package fruos_pkg;
   localparam int unsigned FRUOS_DATA_W     = 8;
   localparam int unsigned FRUOS_ADDR_W     = 7;
   localparam int unsigned FRUOS_FILE_DEPTH = 128;

   localparam logic [7:0] FRUOS_BYTE_ZERO = 8'h00;
   localparam logic [7:0] FRUOS_BYTE_ONE  = 8'h01;
   localparam logic [7:0] FRUOS_BYTE_ONES = 8'hff;
   localparam logic       FRUOS_DEST_ACC  = 1'b0;
   localparam logic       FRUOS_DEST_FILE = 1'b1;
   localparam logic       FRUOS_Z_RESET   = 1'b0;

   typedef enum logic [2:0] {
      complement_file_op     = 3'h0,
      clear_file_op          = 3'h1,
      clear_accumulator_op   = 3'h2,
      decrement_file_op      = 3'h3,
      decrement_skip_zero_op = 3'h4,
      increment_skip_zero_op = 3'h5
   } fruos_op_t;

   typedef enum logic [1:0] {
      FRUOS_ST_EXEC = 2'b00,
      FRUOS_ST_NOP  = 2'b01
   } fruos_state_t;

   function automatic logic fruos_is_zero(input logic [7:0] value);
      return value == FRUOS_BYTE_ZERO;
   endfunction
endpackage
`default_nettype wire

// ===== src/fruos_alu_if.sv
// Purpose: Carrier between the core sequencer and its result logic
// Assumes: Purely combinational signals within one clock domain
// Notes:   Core drives the request side, the result logic the answer side
`default_nettype none
interface fruos_alu_if;
   import fruos_pkg::*;
   fruos_op_t  op;
   logic       dest;
   logic [7:0] operand;
   logic [7:0] result;
   logic       wr_file;
   logic       wr_acc;
   logic       upd_z;
   logic       z_val;
   logic       skip;

   modport alu  (input op, dest, operand, output result, wr_file, wr_acc, upd_z, z_val, skip);
   modport core (output op, dest, operand, input result, wr_file, wr_acc, upd_z, z_val, skip);
endinterface
`default_nettype wire

// ===== src/fruos_alu.sv
// Purpose: Result, destination and flag decisions for each unary operation
// Assumes: Operand already read from the addressed file register
// Notes:   Unknown opcodes produce no write and no flag change
`default_nettype none
module fruos_alu (
   fruos_alu_if.alu a
);
   import fruos_pkg::*;

   always_comb begin
      a.result  = FRUOS_BYTE_ZERO;
      a.wr_file = 1'b0;
      a.wr_acc  = 1'b0;
      a.upd_z   = 1'b0;
      a.skip    = 1'b0;
      unique case (a.op)
         complement_file_op: begin
            a.result  = ~a.operand;
            a.wr_file = (a.dest == FRUOS_DEST_FILE);
            a.wr_acc  = (a.dest == FRUOS_DEST_ACC);
            a.upd_z   = 1'b1;
         end
         clear_file_op: begin
            a.result  = FRUOS_BYTE_ZERO;
            a.wr_file = 1'b1;
            a.upd_z   = 1'b1;
         end
         clear_accumulator_op: begin
            a.result  = FRUOS_BYTE_ZERO;
            a.wr_acc  = 1'b1;
            a.upd_z   = 1'b1;
         end
         decrement_file_op: begin
            a.result  = 8'(a.operand - FRUOS_BYTE_ONE);
            a.wr_file = (a.dest == FRUOS_DEST_FILE);
            a.wr_acc  = (a.dest == FRUOS_DEST_ACC);
            a.upd_z   = 1'b1;
         end
         decrement_skip_zero_op: begin
            a.result  = 8'(a.operand - FRUOS_BYTE_ONE);
            a.wr_file = (a.dest == FRUOS_DEST_FILE);
            a.wr_acc  = (a.dest == FRUOS_DEST_ACC);
            a.skip    = fruos_is_zero(8'(a.operand - FRUOS_BYTE_ONE));
         end
         increment_skip_zero_op: begin
            a.result  = 8'(a.operand + FRUOS_BYTE_ONE);
            a.wr_file = (a.dest == FRUOS_DEST_FILE);
            a.wr_acc  = (a.dest == FRUOS_DEST_ACC);
            a.skip    = fruos_is_zero(8'(a.operand + FRUOS_BYTE_ONE));
         end
         default: begin
            a.result = FRUOS_BYTE_ZERO;
         end
      endcase
      a.z_val = fruos_is_zero(a.result);
   end
endmodule
`default_nettype wire

// ===== src/fruos_core.sv
// Purpose: Execution datapath for single-operand file-register operations with skip
// Assumes: Requests are synchronous to clk; one request per ready cycle
// Notes:   Holds the file registers, accumulator and zero flag of the core
// Notes on behaviour
// - Operand address spans 0 to 127, with a one-bit destination select.
// - Complement inverts the file register into accumulator or file, updating zero.
// - Clear-file writes 00h to the file register and sets zero.
// - Clear-accumulator loads 00h into the accumulator and sets zero; no operand.
// - Decrement subtracts one, routes by destination bit, updates zero.
// - Decrement-and-skip subtracts one, routes by destination, leaves flags alone.
// - Decrement-and-skip with zero result replaces the next instruction by a no-op.
// - Increment-and-skip adds one, routes by destination, leaves flags alone.
// - Increment-and-skip with zero result replaces the next instruction by a no-op.
// - A nonzero skip result lets the next instruction run with no extra cycle.
`default_nettype none
module fruos_core (
   // Clock and reset
   input  wire logic                               clk,
   input  wire logic                               rstn,
   // Operation request
   input  wire logic                               op_valid,
   input  wire fruos_pkg::fruos_op_t               op_code,
   input  wire logic [fruos_pkg::FRUOS_ADDR_W-1:0] op_addr,
   input  wire logic                               op_dest,
   output var  logic                               op_ready,
   // Status
   output var  logic [fruos_pkg::FRUOS_DATA_W-1:0] acc_value,
   output var  logic                               zero_flag,
   output var  logic                               op_done,
   output var  logic                               nop_slot,
   // File register read-back
   input  wire logic [fruos_pkg::FRUOS_ADDR_W-1:0] rd_addr,
   output var  logic [fruos_pkg::FRUOS_DATA_W-1:0] rd_data
);
   import fruos_pkg::*;

   fruos_alu_if alu_bus ();

   fruos_alu u_alu (
      .a (alu_bus.alu)
   );

   fruos_state_t                 state_q,   state_d;
   logic [FRUOS_DATA_W-1:0]      file_q     [FRUOS_FILE_DEPTH];
   logic [FRUOS_DATA_W-1:0]      file_d     [FRUOS_FILE_DEPTH];
   logic [FRUOS_DATA_W-1:0]      acc_q,     acc_d;
   logic                         zero_q,    zero_d;
   logic                         ready_q,   ready_d;
   logic                         done_q,    done_d;
   logic                         nop_q,     nop_d;
   logic [FRUOS_DATA_W-1:0]      rd_q,      rd_d;
   logic                         take;

   assign take            = op_valid && (state_q == FRUOS_ST_EXEC);
   assign alu_bus.op      = op_code;
   assign alu_bus.dest    = op_dest;
   assign alu_bus.operand = file_q[op_addr];

   always_comb begin
      state_d = FRUOS_ST_EXEC;
      file_d  = file_q;
      acc_d   = acc_q;
      zero_d  = zero_q;
      done_d  = 1'b0;
      nop_d   = 1'b0;
      // Read-back shows the file as of the previous edge
      rd_d    = file_q[rd_addr];
      unique case (state_q)
         FRUOS_ST_EXEC: begin
            if (take) begin
               done_d = 1'b1;
               if (alu_bus.wr_file) begin
                  file_d[op_addr] = alu_bus.result;
               end
               if (alu_bus.wr_acc) begin
                  acc_d = alu_bus.result;
               end
               if (alu_bus.upd_z) begin
                  zero_d = alu_bus.z_val;
               end
               if (alu_bus.skip) begin
                  // Mark the cycle of the discarded instruction, not the one after it
                  state_d = FRUOS_ST_NOP;
                  nop_d   = 1'b1;
               end
            end
         end
         FRUOS_ST_NOP: begin
            state_d = FRUOS_ST_EXEC;
         end
         default: begin
            state_d = FRUOS_ST_EXEC;
         end
      endcase
      ready_d = (state_d == FRUOS_ST_EXEC);
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         state_q <= FRUOS_ST_EXEC;
         for (int i = 0; i < FRUOS_FILE_DEPTH; i++) begin
            file_q[i] <= FRUOS_BYTE_ZERO;
         end
         acc_q   <= FRUOS_BYTE_ZERO;
         zero_q  <= FRUOS_Z_RESET;
         ready_q <= 1'b1;
         done_q  <= 1'b0;
         nop_q   <= 1'b0;
         rd_q    <= FRUOS_BYTE_ZERO;
      end else begin
         state_q <= state_d;
         file_q  <= file_d;
         acc_q   <= acc_d;
         zero_q  <= zero_d;
         ready_q <= ready_d;
         done_q  <= done_d;
         nop_q   <= nop_d;
         rd_q    <= rd_d;
      end
   end

   assign op_ready  = ready_q;
   assign acc_value = acc_q;
   assign zero_flag = zero_q;
   assign op_done   = done_q;
   assign nop_slot  = nop_q;
   assign rd_data   = rd_q;

   // Helper copies of the cycle's operand and request for the checks below
   logic [FRUOS_DATA_W-1:0] chk_operand_q;
   logic [FRUOS_ADDR_W-1:0] chk_addr_q;
   always_ff @(posedge clk) begin
      chk_operand_q <= alu_bus.operand;
      chk_addr_q    <= op_addr;
   end

   // Sequences shared by the result and no-op checks
   sequence take_op(fruos_op_t o);
      take && op_code == o;
   endsequence

   sequence nop_then_ready;
      nop_q && !op_ready ##1 op_ready && !nop_q;
   endsequence

   complement_acc_a: assert property (@(posedge clk) disable iff (!rstn)
      take_op(complement_file_op) and op_dest == FRUOS_DEST_ACC |=>
         acc_q == ~chk_operand_q && zero_q == fruos_is_zero(~chk_operand_q))
      else $error("complement result or zero flag wrong");

   clear_file_a: assert property (@(posedge clk) disable iff (!rstn)
      take_op(clear_file_op) |=> file_q[chk_addr_q] == FRUOS_BYTE_ZERO && zero_q)
      else $error("clear file did not zero register and set flag");

   clear_acc_a: assert property (@(posedge clk) disable iff (!rstn)
      take_op(clear_accumulator_op) |=> acc_q == FRUOS_BYTE_ZERO && zero_q)
      else $error("clear accumulator wrong");

   dec_file_a: assert property (@(posedge clk) disable iff (!rstn)
      take_op(decrement_file_op) and op_dest == FRUOS_DEST_FILE |=>
         file_q[chk_addr_q] == 8'(chk_operand_q - FRUOS_BYTE_ONE)
         && zero_q == fruos_is_zero(8'(chk_operand_q - FRUOS_BYTE_ONE)))
      else $error("decrement to file wrong");

   skip_flags_a: assert property (@(posedge clk) disable iff (!rstn)
      take && (op_code == decrement_skip_zero_op || op_code == increment_skip_zero_op)
         |=> $stable(zero_q))
      else $error("skip operation changed zero flag");

   decsz_nop_a: assert property (@(posedge clk) disable iff (!rstn)
      take_op(decrement_skip_zero_op) and alu_bus.operand == FRUOS_BYTE_ONE
         |=> nop_then_ready)
      else $error("decrement skip did not insert one no-op");

   incsz_nop_a: assert property (@(posedge clk) disable iff (!rstn)
      take_op(increment_skip_zero_op) and alu_bus.operand == FRUOS_BYTE_ONES
         and op_dest == FRUOS_DEST_ACC |=> acc_q == FRUOS_BYTE_ZERO ##0 nop_then_ready)
      else $error("increment skip wrap or no-op wrong");

   noskip_a: assert property (@(posedge clk) disable iff (!rstn)
      take && alu_bus.skip == 1'b0 |=> op_ready && !nop_q)
      else $error("no-op inserted for nonzero result");

   incsz_acc_a: assert property (@(posedge clk) disable iff (!rstn)
      take_op(increment_skip_zero_op) and op_dest == FRUOS_DEST_ACC |=>
         acc_q == 8'(chk_operand_q + FRUOS_BYTE_ONE))
      else $error("increment skip result wrong");

   // Destination checks: file side of complement and both skips, accumulator side of decrement
   complement_file_a: assert property (@(posedge clk) disable iff (!rstn)
      take_op(complement_file_op) and op_dest == FRUOS_DEST_FILE |=>
         file_q[chk_addr_q] == ~chk_operand_q && zero_q == fruos_is_zero(~chk_operand_q))
      else $error("complement to file wrong");

   dec_acc_a: assert property (@(posedge clk) disable iff (!rstn)
      take_op(decrement_file_op) and op_dest == FRUOS_DEST_ACC |=>
         acc_q == 8'(chk_operand_q - FRUOS_BYTE_ONE)
         && zero_q == fruos_is_zero(8'(chk_operand_q - FRUOS_BYTE_ONE)))
      else $error("decrement to accumulator wrong");

   decsz_file_a: assert property (@(posedge clk) disable iff (!rstn)
      take_op(decrement_skip_zero_op) and op_dest == FRUOS_DEST_FILE |=>
         file_q[chk_addr_q] == 8'(chk_operand_q - FRUOS_BYTE_ONE))
      else $error("decrement skip result to file wrong");

   incsz_file_a: assert property (@(posedge clk) disable iff (!rstn)
      take_op(increment_skip_zero_op) and op_dest == FRUOS_DEST_FILE |=>
         file_q[chk_addr_q] == 8'(chk_operand_q + FRUOS_BYTE_ONE))
      else $error("increment skip result to file wrong");

   // A request offered in the no-op slot must leave no trace
   slot_refuse_a: assert property (@(posedge clk) disable iff (!rstn)
      nop_q && op_valid |=> !op_done && $stable(acc_q) && $stable(zero_q))
      else $error("request taken in the no-op slot");

   // Only a taken request may raise the done pulse
   done_pulse_a: assert property (@(posedge clk) disable iff (!rstn)
      !take |=> !op_done)
      else $error("done pulse without a taken request");
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// Purpose: Self-checking bench for the file-register unary datapath
// Assumes: Inputs driven at the falling edge; results sampled one falling edge later
// Notes:   File contents are observed through the read-back port
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import fruos_pkg::*;

   logic       clk;
   logic       rstn;
   logic       op_valid;
   fruos_op_t  op_code;
   logic [6:0] op_addr;
   logic       op_dest;
   logic       op_ready;
   logic [7:0] acc_value;
   logic       zero_flag;
   logic       op_done;
   logic       nop_slot;
   logic [6:0] rd_addr;
   logic [7:0] rd_data;
   int         bad_count;
   int         total_checks;

   fruos_core DUT (
      .clk       (clk),
      .rstn      (rstn),
      .op_valid  (op_valid),
      .op_code   (op_code),
      .op_addr   (op_addr),
      .op_dest   (op_dest),
      .op_ready  (op_ready),
      .acc_value (acc_value),
      .zero_flag (zero_flag),
      .op_done   (op_done),
      .nop_slot  (nop_slot),
      .rd_addr   (rd_addr),
      .rd_data   (rd_data)
   );

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One request, taken at the next rising edge; s says whether a no-op slot follows
   task automatic op(input fruos_op_t c, input logic [6:0] a, input logic d, input logic s);
      @(negedge clk);
      op_code  = c;
      op_addr  = a;
      op_dest  = d;
      op_valid = 1'b1;
      @(negedge clk);
      op_valid = 1'b0;
      chk1(op_done, 1'b1);
      chk1(nop_slot, s);
      chk1(op_ready, ~s);
   endtask

   task automatic rd(input logic [6:0] a, input logic [7:0] exp);
      @(negedge clk);
      rd_addr = a;
      @(negedge clk);
      chk8(rd_data, exp);
   endtask

   task automatic t_reset();
      chk8(acc_value, 8'h00);
      chk1(zero_flag, 1'b0);
      chk1(op_ready, 1'b1);
      rd(7'h7f, 8'h00);
      $display("test reset done");
   endtask

   task automatic t_comp();
      op(complement_file_op, 7'h05, 1'b1, 1'b0);
      chk1(zero_flag, 1'b0);
      rd(7'h05, 8'hff);
      op(complement_file_op, 7'h05, 1'b0, 1'b0);
      chk8(acc_value, 8'h00);
      chk1(zero_flag, 1'b1);
      rd(7'h05, 8'hff);
      $display("test complement done");
   endtask

   task automatic t_dec_clr();
      op(decrement_file_op, 7'h7f, 1'b1, 1'b0);
      chk1(zero_flag, 1'b0);
      rd(7'h7f, 8'hff);
      op(decrement_file_op, 7'h05, 1'b0, 1'b0);
      chk8(acc_value, 8'hfe);
      op(clear_file_op, 7'h05, 1'b0, 1'b0);
      chk1(zero_flag, 1'b1);
      chk8(acc_value, 8'hfe);
      rd(7'h05, 8'h00);
      op(complement_file_op, 7'h05, 1'b0, 1'b0);
      chk1(zero_flag, 1'b0);
      op(clear_accumulator_op, 7'h7f, 1'b1, 1'b0);
      chk8(acc_value, 8'h00);
      chk1(zero_flag, 1'b1);
      rd(7'h7f, 8'hff);
      $display("test decrement and clear done");
   endtask

   task automatic t_skip();
      op(decrement_file_op, 7'h14, 1'b0, 1'b0);
      chk8(acc_value, 8'hff);
      op(increment_skip_zero_op, 7'h0a, 1'b1, 1'b0);
      chk1(zero_flag, 1'b0);
      rd(7'h0a, 8'h01);
      @(negedge clk);
      op_code  = decrement_skip_zero_op;
      op_addr  = 7'h0a;
      op_dest  = 1'b1;
      op_valid = 1'b1;
      @(negedge clk);
      chk1(nop_slot, 1'b1);
      chk1(op_ready, 1'b0);
      chk1(op_done, 1'b1);
      // A request in the no-op slot must be dropped
      op_code = clear_accumulator_op;
      @(negedge clk);
      op_valid = 1'b0;
      chk1(op_done, 1'b0);
      chk1(nop_slot, 1'b0);
      chk1(op_ready, 1'b1);
      chk8(acc_value, 8'hff);
      chk1(zero_flag, 1'b0);
      rd(7'h0a, 8'h00);
      op(increment_skip_zero_op, 7'h7f, 1'b0, 1'b1);
      chk8(acc_value, 8'h00);
      chk1(zero_flag, 1'b0);
      rd(7'h7f, 8'hff);
      op(clear_file_op, 7'h0b, 1'b1, 1'b0);
      op(decrement_skip_zero_op, 7'h7f, 1'b0, 1'b0);
      chk8(acc_value, 8'hfe);
      chk1(zero_flag, 1'b1);
      $display("test skip done");
   endtask

   task automatic t_unknown();
      op(fruos_op_t'(3'h6), 7'h7f, 1'b1, 1'b0);
      chk8(acc_value, 8'hfe);
      chk1(zero_flag, 1'b1);
      rd(7'h7f, 8'hff);
      $display("test unknown opcode done");
   endtask

   task automatic t_rerun();
      @(negedge clk);
      rstn = 1'b0;
      @(negedge clk);
      rstn = 1'b1;
      chk8(acc_value, 8'h00);
      chk1(zero_flag, 1'b0);
      chk1(op_ready, 1'b1);
      rd(7'h7f, 8'h00);
      $display("test mid-run reset done");
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      #(25ns * 2000);
      bad_count++;
      results();
   end

   initial begin
      bad_count    = 0;
      total_checks = 0;
      rstn         = 1'b0;
      op_valid     = 1'b0;
      op_code      = complement_file_op;
      op_addr      = 7'h00;
      op_dest      = 1'b0;
      rd_addr      = 7'h00;
      repeat (12) @(negedge clk);
      rstn = 1'b1;
      t_reset();
      t_comp();
      t_dec_clr();
      t_skip();
      t_unknown();
      t_rerun();
      results();
   end
endmodule
`default_nettype wire
